// ===== rtl/ssi_map.svh
// offsets, field positions, reset values and timing counts of the serial shift unit
// ==========================================================================
`ifndef SSI_MAP_SVH
`define SSI_MAP_SVH

// ==========================================================================
// register select offsets
`define SSI_OFS_SHIFT      4'hA
`define SSI_OFS_AUX        4'hB
`define SSI_OFS_FLAGS      4'hD
`define SSI_OFS_ENABLES    4'hE

// ==========================================================================
// field positions
`define SSI_AUX_MODE_HI    4
`define SSI_AUX_MODE_LO    2
`define SSI_SUM_BIT        7
`define SSI_SHIFT_FLAG_BIT 2

// ==========================================================================
// reset values and timing counts
`define SSI_AUX_RST        8'h00
`define SSI_FLAGS_RST      7'h00
`define SSI_ENABLES_RST    7'h00
`define SSI_SHIFT_RST      8'h00
`define SSI_LAST_BIT       3'h7
`define SSI_SYS_HALF       8'h01

`endif

// ===== rtl/ssi_pkg.sv
// types and helper functions of the serial shift unit
`include "ssi_map.svh"

package ssi_pkg;

   // ==========================================================================
   // shifter modes in mode field order
   typedef enum logic [2:0] {
      SM_OFF,
      SM_IN_T2,
      SM_IN_SYS,
      SM_IN_EXT,
      SM_OUT_FREE,
      SM_OUT_T2,
      SM_OUT_SYS,
      SM_OUT_EXT
   } ssi_mode_t;

   // internal serial clock generator states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOW,
      ST_HIGH
   } ssi_state_t;

   // ==========================================================================
   // true for the four shift-out modes
   function automatic logic ssi_is_out(input ssi_mode_t m);
      return (m == SM_OUT_FREE) || (m == SM_OUT_T2) || (m == SM_OUT_SYS) || (m == SM_OUT_EXT);
   endfunction : ssi_is_out

   // true where the serial clock comes from outside
   function automatic logic ssi_is_ext(input ssi_mode_t m);
      return (m == SM_IN_EXT) || (m == SM_OUT_EXT);
   endfunction : ssi_is_ext

   // half period of the generated serial clock in core cycles
   function automatic logic [7:0] ssi_half(input ssi_mode_t m, input logic [7:0] n);
      if ((m == SM_IN_T2) || (m == SM_OUT_T2) || (m == SM_OUT_FREE))
         return (n == 8'h00) ? 8'h01 : n;
      return `SSI_SYS_HALF;
   endfunction : ssi_half

endpackage : ssi_pkg

// ===== rtl/ssi_pin_if.sv
// synchronised pin level and its edges, passed from the synchroniser to the core
`timescale 1ns/1ps

interface ssi_pin_if;
   logic lvl;
   logic rise;
   logic fall;

   modport sync (output lvl, output rise, output fall);
   modport core (input lvl, input rise, input fall);
endinterface : ssi_pin_if

// ===== rtl/ssi_pin_sync.sv
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps

module ssi_pin_sync
   (
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   input  wire logic i_clk_en,
   input  wire logic i_pin,
   ssi_pin_if.sync   pin
   );

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // ==========================================================================
   // synchroniser chain, third stage only for edge finding
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         s1_q <= 1'h1;
         s2_q <= 1'h1;
         s3_q <= 1'h1;
      end
      else if (i_clk_en)
      begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // level and edges seen after the second stage
   assign pin.lvl  = s2_q;
   assign pin.rise = s2_q & ~s3_q;
   assign pin.fall = ~s2_q & s3_q;

endmodule : ssi_pin_sync

// ===== rtl/ssi_top.sv
// serial shift register unit with interrupt flag and enable registers
`timescale 1ns/1ps

module ssi_top
   import ssi_pkg::*;
   #(
   parameter int SHIFT_FLAG_BIT = `SSI_SHIFT_FLAG_BIT
   )
   (
   input  wire logic       I_CORE_CLK,
   input  wire logic       I_RESET,
   input  wire logic       I_CLK_EN,
   input  wire logic       I_CS,
   input  wire logic [3:0] I_RS,
   input  wire logic       I_RW,
   input  wire logic [7:0] I_DATA,
   input  wire logic [6:0] I_FLAG_SET,
   input  wire logic [6:0] I_PORT_CLR,
   input  wire logic [6:0] I_INDEPENDENT,
   input  wire logic [7:0] I_T2_LATCH_LO,
   input  wire logic       I_SCLK,
   input  wire logic       I_SDATA,
   output logic      [7:0] O_DATA,
   output logic            O_DATA_OE,
   output logic            O_IRQ_N,
   output logic            O_IRQ_N_OE,
   output logic            O_SCLK,
   output logic            O_SCLK_OE,
   output logic            O_SDATA,
   output logic            O_SDATA_OE
   );

   // ==========================================================================
   // declarations
   localparam logic [6:0] SHIFT_MASK = 7'h01 << SHIFT_FLAG_BIT;

   logic [7:0]  aux_q;
   logic [6:0]  flags_q;
   logic [6:0]  flags_d;
   logic [6:0]  ena_q;
   logic [6:0]  ena_d;
   logic [7:0]  sr_q;
   logic [7:0]  sr_d;
   logic [7:0]  rdata_q;
   logic        rdata_oe_q;
   logic        irq_n_q;
   logic        irq_oe_q;
   logic        sclk_q;
   logic        sclk_d;
   logic        sclk_oe_q;
   logic        sdo_q;
   logic        sdo_d;
   logic        sdo_oe_q;
   ssi_state_t  st_q;
   ssi_state_t  st_d;
   logic [7:0]  tmr_q;
   logic [7:0]  tmr_d;
   logic [2:0]  cnt_q;
   logic [2:0]  cnt_d;
   logic [2:0]  smp_q;
   logic        smp_d;
   logic        rot;
   logic        done;

   ssi_mode_t   mode;
   logic        is_out;
   logic        is_ext;
   logic        is_int;
   logic [7:0]  half_m1;
   logic        sel_sr;
   logic        sel_aux;
   logic        sel_flags;
   logic        sel_ena;
   logic        wr;
   logic        rd;
   logic        sr_acc;
   logic        sr_wr;
   logic [7:0]  rd_mux;
   logic        rd_mapped;
   logic        irq_any;
   logic [6:0]  set_v;
   logic [6:0]  clr_v;
   logic [6:0]  hold_low;
   logic        shift_in;
   logic [7:0]  sr_base;

   ssi_pin_if   clk_pin ();
   ssi_pin_if   dat_pin ();

   // ==========================================================================
   // pin synchronisers for the serial clock and data lines
   ssi_pin_sync u_clk_sync
      (
      .i_core_clk (I_CORE_CLK),
      .i_reset    (I_RESET),
      .i_clk_en   (I_CLK_EN),
      .i_pin      (I_SCLK),
      .pin        (clk_pin)
      );

   ssi_pin_sync u_dat_sync
      (
      .i_core_clk (I_CORE_CLK),
      .i_reset    (I_RESET),
      .i_clk_en   (I_CLK_EN),
      .i_pin      (I_SDATA),
      .pin        (dat_pin)
      );

   // ==========================================================================
   // register select decode
   assign sel_sr    = I_CS & (I_RS == `SSI_OFS_SHIFT);
   assign sel_aux   = I_CS & (I_RS == `SSI_OFS_AUX);
   assign sel_flags = I_CS & (I_RS == `SSI_OFS_FLAGS);
   assign sel_ena   = I_CS & (I_RS == `SSI_OFS_ENABLES);
   assign rd        = I_CS & I_RW;
   assign wr        = I_CS & ~I_RW;
   assign rd_mapped = sel_sr | sel_aux | sel_flags | sel_ena;
   assign sr_acc    = sel_sr;                       // read or write starts shifting
   assign sr_wr     = sel_sr & ~I_RW;

   // mode decode from the auxiliary control field
   assign mode    = ssi_mode_t'(aux_q[`SSI_AUX_MODE_HI:`SSI_AUX_MODE_LO]);
   assign is_out  = ssi_is_out(mode);
   assign is_ext  = ssi_is_ext(mode);
   assign is_int  = (mode != SM_OFF) && !is_ext;
   assign half_m1 = ssi_half(mode, I_T2_LATCH_LO) - 8'h01;

   // ==========================================================================
   // read data selection
   assign irq_any = |(flags_q & ena_q);
   assign rd_mux  = sel_sr    ? sr_q :
                    sel_aux   ? aux_q :
                    sel_flags ? {irq_any, flags_q} :
                    sel_ena   ? {1'h1, ena_q} :
                    8'h00;

   // ==========================================================================
   // flag sources, clears and hold-off
   assign set_v    = (I_FLAG_SET & ~SHIFT_MASK) | (done ? SHIFT_MASK : 7'h00);
   assign clr_v    = ((sel_flags & wr) ? I_DATA[6:0] : 7'h00)
                   | (I_PORT_CLR & ~I_INDEPENDENT)
                   | (sr_acc ? SHIFT_MASK : 7'h00);
   assign hold_low = (mode == SM_OFF) ? SHIFT_MASK : 7'h00;
   assign flags_d  = ((flags_q & ~clr_v) | set_v) & ~hold_low; // set beats clear

   // enable update, data bit 7 picks set or clear
   assign ena_d = !(sel_ena & wr) ? ena_q :
                  I_DATA[`SSI_SUM_BIT] ? (ena_q | I_DATA[6:0]) :
                  (ena_q & ~I_DATA[6:0]);

   // ==========================================================================
   // serial clock generator and bit counter
   always_comb
   begin
      st_d   = st_q;
      tmr_d  = tmr_q;
      cnt_d  = cnt_q;
      sclk_d = sclk_q;
      smp_d  = 1'h0;
      rot    = 1'h0;
      done   = 1'h0;
      case (st_q)
         ST_IDLE:
         begin
            sclk_d = 1'h1;
            if (mode == SM_OUT_FREE)                // free run needs no access
            begin
               st_d   = ST_LOW;
               sclk_d = 1'h0;
               tmr_d  = half_m1;
               rot    = 1'h1;
            end
         end
         ST_LOW:
         begin
            if (tmr_q == 8'h00)
            begin
               st_d   = ST_HIGH;
               sclk_d = 1'h1;
               tmr_d  = half_m1;
               smp_d  = !is_out;                    // sample next cycle
            end
            else
               tmr_d = tmr_q - 8'h01;
         end
         ST_HIGH:
         begin
            if (tmr_q != 8'h00)
               tmr_d = tmr_q - 8'h01;
            else if ((cnt_q == `SSI_LAST_BIT) && (mode != SM_OUT_FREE))
            begin
               st_d = (smp_q == 3'h0) ? ST_IDLE : ST_HIGH; // last bit in first
               done = (smp_q == 3'h0);
            end
            else
            begin
               st_d   = ST_LOW;
               sclk_d = 1'h0;
               tmr_d  = half_m1;
               rot    = is_out;
               if (mode != SM_OUT_FREE)
                  cnt_d = cnt_q + 3'h1;             // modulo-8 count
            end
         end
         default:
            st_d = ST_IDLE;
      endcase
      if (!is_int)
      begin
         st_d   = ST_IDLE;
         sclk_d = 1'h1;
         smp_d  = 1'h0;
         rot    = 1'h0;
         done   = 1'h0;
         if (sr_acc)
            cnt_d = 3'h0;                           // access restarts count
         else if (is_ext && clk_pin.rise)
         begin
            cnt_d = cnt_q + 3'h1;                   // counts without stopping
            done  = (cnt_q == `SSI_LAST_BIT);
         end
         rot = is_ext & is_out & clk_pin.fall;
      end
      else if (sr_acc)
      begin
         st_d   = ST_LOW;
         sclk_d = 1'h0;
         tmr_d  = half_m1;
         cnt_d  = 3'h0;
         smp_d  = 1'h0;
         rot    = is_out;
         done   = 1'h0;
      end
   end

   // ==========================================================================
   // shift data path; sampled bits wait out the pin synchroniser
   assign shift_in = (smp_q[2] & ~sr_acc) | (is_ext & !is_out & clk_pin.rise);
   assign sr_base  = sr_wr ? I_DATA : sr_q;
   assign sr_d     = rot      ? {sr_base[6:0], sr_base[7]} :
                     shift_in ? {sr_base[6:0], dat_pin.lvl} :
                     sr_base;
   assign sdo_d    = rot ? sr_base[7] : sdo_q;                 // last level holds

   // ==========================================================================
   // control registers
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET)
      begin
         aux_q   <= `SSI_AUX_RST;
         flags_q <= `SSI_FLAGS_RST;
         ena_q   <= `SSI_ENABLES_RST;
      end
      else if (I_CLK_EN)
      begin
         if (sel_aux & wr)
            aux_q <= I_DATA;
         flags_q <= flags_d;
         ena_q   <= ena_d;
      end
   end

   // read data and interrupt pin registers
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET)
      begin
         rdata_q    <= 8'h00;
         rdata_oe_q <= 1'h0;
         irq_n_q    <= 1'h1;
         irq_oe_q   <= 1'h0;
      end
      else if (I_CLK_EN)
      begin
         if (rd)
            rdata_q <= rd_mux;
         rdata_oe_q <= rd & rd_mapped;
         irq_n_q    <= ~|(flags_d & ena_d);
         irq_oe_q   <= |(flags_d & ena_d);          // drive only low
      end
   end

   // shifter state registers
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET)
      begin
         st_q  <= ST_IDLE;
         tmr_q <= 8'h00;
         cnt_q <= 3'h0;
         smp_q <= 3'h0;
         sr_q  <= `SSI_SHIFT_RST;
      end
      else if (I_CLK_EN)
      begin
         st_q  <= st_d;
         tmr_q <= tmr_d;
         cnt_q <= cnt_d;
         smp_q <= sr_acc ? 3'h0 : {smp_q[1:0], smp_d}; // pin level of the cycle after rise
         sr_q  <= sr_d;
      end
   end

   // serial pin registers
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET)
      begin
         sclk_q    <= 1'h1;
         sclk_oe_q <= 1'h0;
         sdo_q     <= 1'h0;
         sdo_oe_q  <= 1'h0;
      end
      else if (I_CLK_EN)
      begin
         sclk_q    <= sclk_d;
         sclk_oe_q <= is_int;                       // external modes leave clock input
         sdo_q     <= sdo_d;
         sdo_oe_q  <= is_out;
      end
   end

   // ==========================================================================
   // outputs straight from registers
   assign O_DATA     = rdata_q;
   assign O_DATA_OE  = rdata_oe_q;
   assign O_IRQ_N    = irq_n_q;
   assign O_IRQ_N_OE = irq_oe_q;
   assign O_SCLK     = sclk_q;
   assign O_SCLK_OE  = sclk_oe_q;
   assign O_SDATA    = sdo_q;
   assign O_SDATA_OE = sdo_oe_q;

endmodule : ssi_top

// ===== testbench/ssi_top_sva.sv
// port assertions for the serial shift unit
`timescale 1ns/1ps

module ssi_top_sva
   (
   input wire logic       I_CORE_CLK,
   input wire logic       I_RESET,
   input wire logic       I_CLK_EN,
   input wire logic       I_CS,
   input wire logic [3:0] I_RS,
   input wire logic       I_RW,
   input wire logic [7:0] I_DATA,
   input wire logic [6:0] I_FLAG_SET,
   input wire logic [7:0] I_T2_LATCH_LO,
   input wire logic [7:0] O_DATA,
   input wire logic       O_DATA_OE,
   input wire logic       O_IRQ_N,
   input wire logic       O_IRQ_N_OE,
   input wire logic       O_SCLK,
   input wire logic       O_SCLK_OE,
   input wire logic       O_SDATA,
   input wire logic       O_SDATA_OE
   );
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_RESET);

   // ==========
   // access decode, mode shadow, low phase length
   wire logic       acc  = I_CS && I_CLK_EN;
   wire logic       rd   = acc && I_RW;
   wire logic       wr   = acc && !I_RW;
   wire logic       map  = I_RS inside {4'hA, 4'hB, 4'hD, 4'hE};
   wire logic [7:0] half = (I_T2_LATCH_LO == 8'h00) ? 8'h01 : I_T2_LATCH_LO;
   logic      [2:0] mode_q;
   logic      [7:0] low_q;
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET)
         mode_q <= 3'h0;
      else if (wr && I_RS == 4'hB)
         mode_q <= I_DATA[4:2];
   end
   // restarted by a shift data access, which may restart a low phase
   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_RESET || O_SCLK || (acc && I_RS == 4'hA))
         low_q <= 8'h00;
      else
         low_q <= low_q + 8'h01;
   end

   // ==========
   // assertions
   a_irq_pin_pair: assert property (O_IRQ_N == !O_IRQ_N_OE)
      else $error("irq level and enable disagree");
   a_read_answer: assert property (rd |=> O_DATA_OE == $past(map))
      else $error("read answer strobe wrong");
   a_enable_top_one: assert property (rd && I_RS == 4'hE |=> O_DATA[7])
      else $error("enable read bit 7 low");
   a_flag_summary: assert property (rd && I_RS == 4'hD |=> O_DATA[7] == $past(O_IRQ_N_OE))
      else $error("flag summary bit wrong");
   a_off_quiet: assert property ($stable(mode_q) && mode_q == 3'h0 |-> !O_SCLK_OE && !O_SDATA_OE)
      else $error("pins driven while off");
   a_pin_drive_modes: assert property ($stable(mode_q) |-> O_SDATA_OE == mode_q[2] &&
      O_SCLK_OE == (mode_q inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6}))
      else $error("pin drive does not match mode");
   a_timer_half: assert property ($stable(mode_q) && mode_q inside {3'h1, 3'h5} && $rose(O_SCLK)
      |-> low_q == half)
      else $error("timer low phase length wrong");
   a_sys_half: assert property ($stable(mode_q) && mode_q inside {3'h2, 3'h6} && $fell(O_SCLK)
      |=> $rose(O_SCLK))
      else $error("core rate low phase not one cycle");
   a_out_on_fall: assert property ($stable(mode_q) && mode_q inside {3'h5, 3'h6} && $changed(O_SDATA)
      |-> $fell(O_SCLK))
      else $error("data changed off a clock fall");
   a_enable_clear: assert property (wr && I_RS == 4'hE && I_DATA == 8'h7F |=> O_IRQ_N)
      else $error("irq held after enables cleared");
   a_flag_clear: assert property (wr && I_RS == 4'hD && I_DATA == 8'h7F && I_FLAG_SET == 7'h00
      |=> O_IRQ_N)
      else $error("irq held after flags cleared");
   c_irq_raised: cover property ($fell(O_IRQ_N));
   c_free_pulse: cover property (mode_q == 3'h4 && $rose(O_SCLK));
   c_sum_read: cover property (rd && I_RS == 4'hD && !O_IRQ_N);
endmodule : ssi_top_sva

bind ssi_top ssi_top_sva i_ssi_top_sva (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET),
   .I_CLK_EN(I_CLK_EN), .I_CS(I_CS), .I_RS(I_RS), .I_RW(I_RW), .I_DATA(I_DATA),
   .I_FLAG_SET(I_FLAG_SET), .I_T2_LATCH_LO(I_T2_LATCH_LO), .O_DATA(O_DATA),
   .O_DATA_OE(O_DATA_OE), .O_IRQ_N(O_IRQ_N), .O_IRQ_N_OE(O_IRQ_N_OE), .O_SCLK(O_SCLK),
   .O_SCLK_OE(O_SCLK_OE), .O_SDATA(O_SDATA), .O_SDATA_OE(O_SDATA_OE));

// ===== testbench/ssi_serial_dev.sv
// serial device on the far side of the clock and data lines
`timescale 1ns/1ps

module ssi_serial_dev
   (
   input  wire logic       i_sclk,
   input  wire logic       i_sdata,
   input  wire logic       i_clr,
   input  wire logic       i_ext_go,
   input  wire logic [7:0] i_tx,
   output logic            o_sclk,
   output logic            o_sdata,
   output logic      [7:0] o_rx,
   output int              o_pulses
   );
   int idx;
   initial
   begin
      o_sclk = 1'b1;
      o_sdata = 1'b1;
   end
   // restart the counts of a new transfer
   always @(posedge i_clr)
   begin
      o_rx = 8'h00;
      o_pulses = 0;
      idx = 0;
   end
   // capture the line on each clock rise
   always @(posedge i_sclk)
   begin
      o_rx = {o_rx[6:0], i_sdata};
      o_pulses = o_pulses + 1;
   end
   // next bit, top first, on each fall; stands half a period past the rise
   always @(negedge i_sclk)
   begin
      o_sdata = i_tx[3'h7 - idx[2:0]];
      idx = idx + 1;
   end
   // eight pulses of 800 ns, off phase with the core clock
   always @(posedge i_ext_go)
   begin
      #37;
      repeat (8)
      begin
         o_sclk = 1'b0;
         #400;
         o_sclk = 1'b1;
         #400;
      end
   end
endmodule : ssi_serial_dev

// ===== testbench/ssi_top_test.sv
// self-checking bench for the serial shift unit
`timescale 1ns/1ps

module ssi_top_test;
   // ==========
   // stimulus, lines and partner
   logic       core_clk = 1'b0;
   logic       reset    = 1'b1;
   logic       en       = 1'b1;
   logic       cs       = 1'b0;
   logic       rw       = 1'b1;
   logic [3:0] rs       = 4'h0;
   logic [7:0] wdata    = 8'h00;
   logic [6:0] flag_set = 7'h00;
   logic [6:0] port_clr = 7'h00;
   logic [6:0] indep    = 7'h00;
   logic [7:0] t2_lo    = 8'h03;
   logic [7:0] tx       = 8'h00;
   logic       clr      = 1'b0;
   logic       go       = 1'b0;
   logic [7:0] rdata, rx;
   logic       rdata_oe, irq_n, sclk_o, sclk_oe, sdata_o, sdata_oe, dev_sclk, dev_sdata;
   int         pulses, i, k;
   int         n_errors = 0;
   int         comparisons = 0;
   int         cycles = 0;
   wire logic  sclk_line  = sclk_oe ? sclk_o : dev_sclk;
   wire logic  sdata_line = sdata_oe ? sdata_o : dev_sdata;
   logic [2:0] modes [6] = '{3'h6, 3'h5, 3'h2, 3'h1, 3'h7, 3'h3};
   logic [7:0] bytes [6] = '{8'hA5, 8'h81, 8'h96, 8'h5A, 8'hC3, 8'h3C};

   always #50 core_clk = ~core_clk;

   ssi_top i_ssi_top (.I_CORE_CLK(core_clk), .I_RESET(reset), .I_CLK_EN(en), .I_CS(cs),
      .I_RS(rs), .I_RW(rw), .I_DATA(wdata), .I_FLAG_SET(flag_set), .I_PORT_CLR(port_clr),
      .I_INDEPENDENT(indep), .I_T2_LATCH_LO(t2_lo), .I_SCLK(sclk_line), .I_SDATA(sdata_line),
      .O_DATA(rdata), .O_DATA_OE(rdata_oe), .O_IRQ_N(irq_n), .O_IRQ_N_OE(), .O_SCLK(sclk_o),
      .O_SCLK_OE(sclk_oe), .O_SDATA(sdata_o), .O_SDATA_OE(sdata_oe));
   ssi_serial_dev i_ssi_serial_dev (.i_sclk(sclk_line), .i_sdata(sdata_line), .i_clr(clr),
      .i_ext_go(go), .i_tx(tx), .o_sclk(dev_sclk), .o_sdata(dev_sdata), .o_rx(rx),
      .o_pulses(pulses));

   // ==========
   // tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one register access, then one idle cycle for the answer
   task automatic xfer(input logic r, input logic [3:0] a, input logic [7:0] d);
      cs <= 1'b1;
      rw <= r;
      rs <= a;
      wdata <= d;
      @(posedge core_clk);
      cs <= 1'b0;
      @(posedge core_clk);
   endtask : xfer
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      xfer(1'b1, a, 8'h00);
      check(rdata, e);
   endtask : rd
   // set the mode, restart the partner, load and start the shifter
   task automatic shift(input logic [2:0] m, input logic [7:0] d);
      tx <= d;
      go <= 1'b0;
      clr <= 1'b1;
      xfer(1'b0, 4'hB, {3'h0, m, 2'h0});
      clr <= 1'b0;
      xfer(1'b0, 4'hA, d);
      go <= (m[1:0] == 2'h3);
   endtask : shift
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   // hang guard
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         stop_test();
      end
   end

   // ==========
   // main sequence
   initial
   begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(4'hB, 8'h00);
      rd(4'hD, 8'h00);
      rd(4'hE, 8'h80);
      rd(4'h3, 8'h00);
      check({7'h00, rdata_oe}, 8'h00);
      xfer(1'b0, 4'hE, 8'hFF);
      rd(4'hE, 8'hFF);
      xfer(1'b0, 4'hE, 8'h7B);
      rd(4'hE, 8'h84);
      flag_set <= 7'h03;
      @(posedge core_clk);
      flag_set <= 7'h00;
      rd(4'hD, 8'h03);
      xfer(1'b0, 4'hE, 8'h81);
      rd(4'hD, 8'h83);
      check({7'h00, irq_n}, 8'h00);
      xfer(1'b0, 4'hD, 8'h80);
      rd(4'hD, 8'h83);
      indep <= 7'h01;
      port_clr <= 7'h01;
      @(posedge core_clk);
      port_clr <= 7'h00;
      rd(4'hD, 8'h83);
      indep <= 7'h00;
      port_clr <= 7'h01;
      @(posedge core_clk);
      port_clr <= 7'h00;
      rd(4'hD, 8'h02);
      xfer(1'b0, 4'hD, 8'h7F);
      rd(4'hD, 8'h00);
      xfer(1'b0, 4'hE, 8'h7F);
      rd(4'hE, 8'h80);
      xfer(1'b0, 4'hE, 8'h84);
      // a write while the clock enable is low must be ignored
      en <= 1'b0;
      xfer(1'b0, 4'hE, 8'hFF);
      en <= 1'b1;
      rd(4'hE, 8'h84);
      // every counted mode: eight pulses, flag, data; clear by access in external modes, by mode off in the rest
      for (i = 0; i < 6; i++)
      begin
         shift(modes[i], bytes[i]);
         for (k = 0; k < 100 && irq_n !== 1'b0; k++)
            @(posedge core_clk);
         check({7'h00, irq_n}, 8'h00);
         if (modes[i][2] == 1'b1)
            check(rx, bytes[i]);
         if (modes[i][1:0] != 2'h3)
            xfer(1'b0, 4'hB, 8'h00);
         check(pulses[7:0], 8'h08);
         rd(4'hA, bytes[i]);
         check({7'h00, irq_n}, 8'h01);
      end
      // disabled: register kept, no pulses
      shift(3'h0, 8'h77);
      repeat (40) @(posedge core_clk);
      check(pulses[7:0], 8'h00);
      rd(4'hA, 8'h77);
      // free running: same byte twice over, never a flag
      t2_lo <= 8'h02;
      shift(3'h4, 8'h3C);
      for (k = 0; k < 200 && pulses < 16; k++)
         @(posedge core_clk);
      check(rx, 8'h3C);
      check({7'h00, irq_n}, 8'h01);
      stop_test();
   end
endmodule : ssi_top_test
